// ### hdl/dims_cfg.svh
/*
 * constants of the dac input mode select block: offsets, field positions,
 * reset values and timing figures.
 * assumes it is included once per compilation unit by its bare name.
 */
// Overview of operation
// - strap low selects registers, high selects pins
// - pin control ignores registers, and vice versa
// - pin control offers only the shared functions
// - pcm takes bit, frame and serial pins
// - bitstream select 1 forces bitstream mode
// - pin group picks dedicated or shared pins
// - mode change settles; host waits four periods
// - external filter bit selects external filter mode
// - filter switch needs reset and long settle
// - both bits set still means bitstream mode
// - reset gives pcm and default clock ratios
// - default formats; slot and cascade pcm only
// - documented register defaults after reset
// - each setting acts only in its modes
// - zero flag polarity selectable, active high default
`ifndef DIMS_CFG_SVH
`define DIMS_CFG_SVH
// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define DIMS_ADR_FMT 4'h0
`define DIMS_ADR_FILT 4'h1
`define DIMS_ADR_ROUTE 4'h2
`define DIMS_ADR_VOL1 4'h3
`define DIMS_ADR_VOL2 4'h4
`define DIMS_ADR_POL 4'h5
`define DIMS_ADR_BSPATH 4'h6
`define DIMS_ADR_ALIGN 4'h7
`define DIMS_ADR_STAT 4'h8
`define DIMS_ADR_BSFILT 4'h9
`define DIMS_ADR_SLOT 4'hA
`define DIMS_ADR_CASC 4'hB
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define DIMS_B_IRST_N 0
`define DIMS_B_FMT 1
`define DIMS_B_EXTRAT 4
`define DIMS_B_EXT 6
`define DIMS_B_MUTE 0
`define DIMS_B_EMPH 1
`define DIMS_B_SHORT 5
`define DIMS_B_ZDEN 7
`define DIMS_B_BSSEL 0
`define DIMS_B_BSRAT 1
`define DIMS_B_MONO 3
`define DIMS_B_ZPOL 4
`define DIMS_B_CHSEL 5
`define DIMS_B_GROUP 6
`define DIMS_B_GENTLE 2
`define DIMS_B_BSPATH 1
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define DIMS_RST_FMT 8'h24
`define DIMS_RST_FILT 8'h20
`define DIMS_RST_ROUTE 8'h24
`define DIMS_RST_VOL 8'hFF
`define DIMS_RST_ZERO 8'h00
`define DIMS_RST_ALIGN 8'h01
// -----------------------------------------------------------------
// timing, in sample periods and hertz
// -----------------------------------------------------------------
`define DIMS_MODE_SETTLE_FS 3
`define DIMS_FILT_SETTLE_FS 3000
`define DIMS_CLK_HZ 20000000
`define DIMS_FS_HZ 44100
`endif

// ### hdl/dims_pkg.sv
/*
 * types of the dac input mode select block.
 * assumes nothing beyond a systemverilog compiler.
 */
package dims_pkg;
    // conversion mode, gray along pcm, external filter, bitstream
    typedef enum logic [1:0] {
        DIMS_PCM = 2'h0,
        DIMS_EXTF = 2'h1,
        DIMS_DSD = 2'h3
    } dims_mode_t;
    // configuration pins read under pin control
    typedef struct packed {
        logic [2:0] input_format_sel;
        logic short_delay_filter_sel;
        logic extra_gentle_rolloff_sel;
        logic [1:0] emphasis_curve_sel;
        logic soft_silence;
        logic [1:0] output_polarity_flip;
        logic [1:0] slot_mode;
    } dims_pin_cfg_t;
    // settings presented to the datapath
    typedef struct packed {
        dims_mode_t mode;
        logic bitstream_pin_group_sel;
        logic core_reset;
        logic [2:0] input_format_sel;
        logic short_delay_filter_sel;
        logic extra_gentle_rolloff_sel;
        logic [1:0] emphasis_curve_sel;
        logic [1:0] slot_mode;
        logic cascade_en;
        logic [7:0] volume_level_first;
        logic [7:0] volume_level_second;
        logic mono;
        logic channel_source_sel;
        logic [1:0] output_polarity_flip;
        logic soft_silence;
        logic [1:0] bitstream_clock_ratio;
        logic bitstream_path_sel;
        logic bitstream_filter_sel;
        logic full_scale_bitstream_silence;
        logic [1:0] external_filter_clock_ratio;
        logic clock_align_en;
    } dims_cfg_t;
    // shared and dedicated input pins
    typedef struct packed {
        logic j1;
        logic h1;
        logic g1;
        logic b1;
        logic b2;
        logic word_clk;
    } dims_pins_t;
    // samples handed to the datapath on the link clock
    typedef struct packed {
        logic valid;
        logic pcm_serial;
        logic pcm_frame;
        logic left_bit;
        logic right_bit;
        logic word_clk;
    } dims_lnk_out_t;
endpackage

// ### hdl/dims_top.sv
/*
 * dac input mode select: register file, control source choice, mode
 * decode with settling, and link-side pin routing.
 * assumes register writes come decoded from the control port on clk_sys,
 * and that clk_link is the selected serial clock of the audio source.
 */
`include "dims_cfg.svh"
module dims_top
    import dims_pkg::*;
#(
    parameter int unsigned CLK_HZ = `DIMS_CLK_HZ,
    parameter int unsigned FS_HZ = `DIMS_FS_HZ,
    // filter switch settle, long enough to shorten in simulation
    parameter longint unsigned FILT_SETTLE_CYC =
        (longint'(`DIMS_FILT_SETTLE_FS) * CLK_HZ + FS_HZ - 1) / FS_HZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic control_source_strap,
    input wire dims_pin_cfg_t pin_cfg,
    input wire logic reg_wr,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic zero_detected,
    output logic zero_flag_out,
    output dims_cfg_t cfg,
    output logic mode_settling,
    input wire logic clk_link,
    input wire dims_pins_t pins,
    output dims_lnk_out_t lnk_out
);
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam longint unsigned MODE_CYC =
        (longint'(`DIMS_MODE_SETTLE_FS) * CLK_HZ + FS_HZ - 1) / FS_HZ;
    localparam logic [23:0] MODE_CNT = 24'(MODE_CYC);
    localparam logic [23:0] FILT_CNT = 24'(FILT_SETTLE_CYC);

    // -----------------------------------------------------------------
    // system domain state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic strap_meta; // first synchroniser stage
        logic strap_sync; // usable strap level
        dims_pin_cfg_t pin_meta;
        dims_pin_cfg_t pin_sync;
        logic [15:0][7:0] regs; // index = offset
        logic [2:0] route; // mode and pin group in force
        logic [23:0] settle; // cycles left of a mode change
        logic settling; // counter not yet empty, kept in a flop for the pin
        logic [7:0] rdata;
        logic zflag;
        dims_cfg_t cfg;
    } dims_sys_t;

    dims_sys_t q_r; // registered system state
    dims_sys_t q_nxt; // next system state

    // offsets that hold a register
    function automatic logic dims_mapped(input logic [3:0] a);
        case (a)
            `DIMS_ADR_STAT, 4'hC, 4'hD, 4'hE, 4'hF: dims_mapped = 1'b0;
            default: dims_mapped = 1'b1;
        endcase
    endfunction

    // reset value per offset
    function automatic logic [7:0] dims_rst_val(input logic [3:0] a);
        case (a)
            `DIMS_ADR_FMT: dims_rst_val = `DIMS_RST_FMT;
            `DIMS_ADR_FILT: dims_rst_val = `DIMS_RST_FILT;
            `DIMS_ADR_ROUTE: dims_rst_val = `DIMS_RST_ROUTE;
            `DIMS_ADR_VOL1, `DIMS_ADR_VOL2: dims_rst_val = `DIMS_RST_VOL;
            `DIMS_ADR_ALIGN: dims_rst_val = `DIMS_RST_ALIGN;
            default: dims_rst_val = `DIMS_RST_ZERO;
        endcase
    endfunction

    // bitstream select wins over the filter bit
    function automatic dims_mode_t dims_decode(input logic bs, input logic ext);
        if (bs) begin
            dims_decode = DIMS_DSD;
        end else if (ext) begin
            dims_decode = DIMS_EXTF;
        end else begin
            dims_decode = DIMS_PCM;
        end
    endfunction

    // register snapshot used by the decode
    logic [7:0] r_fmt;
    logic [7:0] r_filt;
    logic [7:0] r_route;
    logic pin_ctrl; // high while the strap selects pin control
    dims_mode_t mode_now;
    logic [2:0] route_now;
    assign r_fmt = q_r.regs[`DIMS_ADR_FMT];
    assign r_filt = q_r.regs[`DIMS_ADR_FILT];
    assign r_route = q_r.regs[`DIMS_ADR_ROUTE];
    assign pin_ctrl = q_r.strap_sync;
    // pin control freezes pcm, registers are not consulted
    assign mode_now = pin_ctrl ? DIMS_PCM :
        dims_decode(r_route[`DIMS_B_BSSEL], r_fmt[`DIMS_B_EXT]);
    assign route_now = {mode_now,
        (!pin_ctrl && mode_now == DIMS_DSD) ? r_route[`DIMS_B_GROUP] : 1'b0};

    // -----------------------------------------------------------------
    // system next state
    // -----------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        if (ce) begin
            // strap and pins pass two flops before use
            q_nxt.strap_meta = control_source_strap;
            q_nxt.strap_sync = q_r.strap_meta;
            q_nxt.pin_meta = pin_cfg;
            q_nxt.pin_sync = q_r.pin_meta;
            // writes land even under pin control but are not applied
            if (reg_wr && dims_mapped(reg_addr)) begin
                q_nxt.regs[reg_addr] = reg_wdata;
            end
            // read returns the register or the block's own state
            if (reg_addr == `DIMS_ADR_STAT) begin
                q_nxt.rdata = {4'h0, q_r.strap_sync, q_r.settle != 24'h0,
                    q_r.route[2:1]};
            end else if (dims_mapped(reg_addr)) begin
                q_nxt.rdata = q_r.regs[reg_addr];
            end else begin
                q_nxt.rdata = 8'h00;
            end
            // a route change starts the settling window
            if (route_now != q_r.route) begin
                q_nxt.route = route_now;
                // pcm to or from external filter swaps the whole filter
                if (route_now[2:1] != 2'(DIMS_DSD) &&
                        q_r.route[2:1] != 2'(DIMS_DSD)) begin
                    q_nxt.settle = FILT_CNT;
                end else begin
                    q_nxt.settle = MODE_CNT;
                end
            end else if (q_r.settle != 24'h0) begin
                q_nxt.settle = q_r.settle - 24'h1;
            end
            q_nxt.settling = q_nxt.settle != 24'h0;
            // settings shared by both control sources
            q_nxt.cfg.mode = dims_mode_t'(q_r.route[2:1]);
            q_nxt.cfg.bitstream_pin_group_sel = q_r.route[0];
            if (pin_ctrl) begin
                // only shared functions, the rest at defaults except clock alignment, held off
                q_nxt.cfg.input_format_sel = q_r.pin_sync.input_format_sel;
                q_nxt.cfg.short_delay_filter_sel = q_r.pin_sync.short_delay_filter_sel;
                q_nxt.cfg.extra_gentle_rolloff_sel = q_r.pin_sync.extra_gentle_rolloff_sel;
                q_nxt.cfg.emphasis_curve_sel = q_r.pin_sync.emphasis_curve_sel;
                q_nxt.cfg.slot_mode = q_r.pin_sync.slot_mode;
                q_nxt.cfg.output_polarity_flip = q_r.pin_sync.output_polarity_flip;
                q_nxt.cfg.soft_silence = q_r.pin_sync.soft_silence;
                q_nxt.cfg.volume_level_first = `DIMS_RST_VOL;
                q_nxt.cfg.volume_level_second = `DIMS_RST_VOL;
                q_nxt.cfg.mono = 1'b0;
                q_nxt.cfg.channel_source_sel = 1'b1;
                q_nxt.cfg.full_scale_bitstream_silence = 1'b0;
                q_nxt.cfg.clock_align_en = 1'b0;
                q_nxt.cfg.cascade_en = 1'b0;
                q_nxt.cfg.core_reset = q_r.settle != 24'h0;
                q_nxt.zflag = 1'b0; // no zero detection
            end else begin
                q_nxt.cfg.input_format_sel = r_fmt[`DIMS_B_FMT +: 3];
                q_nxt.cfg.short_delay_filter_sel = r_filt[`DIMS_B_SHORT];
                q_nxt.cfg.extra_gentle_rolloff_sel =
                    q_r.regs[`DIMS_ADR_POL][`DIMS_B_GENTLE];
                q_nxt.cfg.emphasis_curve_sel = r_filt[`DIMS_B_EMPH +: 2];
                q_nxt.cfg.slot_mode = q_r.regs[`DIMS_ADR_SLOT][1:0];
                q_nxt.cfg.output_polarity_flip = q_r.regs[`DIMS_ADR_POL][1:0];
                q_nxt.cfg.soft_silence = r_filt[`DIMS_B_MUTE];
                q_nxt.cfg.volume_level_first = q_r.regs[`DIMS_ADR_VOL1];
                q_nxt.cfg.volume_level_second = q_r.regs[`DIMS_ADR_VOL2];
                q_nxt.cfg.mono = r_route[`DIMS_B_MONO];
                q_nxt.cfg.channel_source_sel = r_route[`DIMS_B_CHSEL];
                q_nxt.cfg.full_scale_bitstream_silence = q_r.regs[`DIMS_ADR_BSPATH][0];
                q_nxt.cfg.clock_align_en = q_r.regs[`DIMS_ADR_ALIGN][0];
                q_nxt.cfg.cascade_en = q_r.regs[`DIMS_ADR_CASC][0];
                // datapath held while the reset bit is low or settling
                q_nxt.cfg.core_reset = !r_fmt[`DIMS_B_IRST_N] || q_r.settle != 24'h0;
                q_nxt.zflag = (r_filt[`DIMS_B_ZDEN] & zero_detected)
                    ^ r_route[`DIMS_B_ZPOL];
            end
            // mode-limited settings read zero outside their modes
            if (q_r.route[2:1] != 2'(DIMS_PCM)) begin
                q_nxt.cfg.emphasis_curve_sel = 2'h0;
                q_nxt.cfg.short_delay_filter_sel = 1'b0;
                q_nxt.cfg.extra_gentle_rolloff_sel = 1'b0;
                q_nxt.cfg.slot_mode = 2'h0;
                q_nxt.cfg.cascade_en = 1'b0;
            end
            if (q_r.route[2:1] == 2'(DIMS_DSD)) begin
                q_nxt.cfg.bitstream_clock_ratio = r_route[`DIMS_B_BSRAT +: 2];
                q_nxt.cfg.bitstream_path_sel = q_r.regs[`DIMS_ADR_BSPATH][`DIMS_B_BSPATH];
                q_nxt.cfg.bitstream_filter_sel = q_r.regs[`DIMS_ADR_BSFILT][0];
                q_nxt.cfg.clock_align_en = 1'b0;
            end else begin
                q_nxt.cfg.bitstream_clock_ratio = 2'h0;
                q_nxt.cfg.bitstream_path_sel = 1'b0;
                q_nxt.cfg.bitstream_filter_sel = 1'b0;
                q_nxt.cfg.full_scale_bitstream_silence = 1'b0;
            end
            q_nxt.cfg.external_filter_clock_ratio =
                (q_r.route[2:1] == 2'(DIMS_EXTF)) ? r_fmt[`DIMS_B_EXTRAT +: 2] : 2'h0;
        end
    end

    // -----------------------------------------------------------------
    // system registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_r <= '0;
            q_r.regs[`DIMS_ADR_FMT] <= `DIMS_RST_FMT;
            q_r.regs[`DIMS_ADR_FILT] <= `DIMS_RST_FILT;
            q_r.regs[`DIMS_ADR_ROUTE] <= `DIMS_RST_ROUTE;
            q_r.regs[`DIMS_ADR_VOL1] <= `DIMS_RST_VOL;
            q_r.regs[`DIMS_ADR_VOL2] <= `DIMS_RST_VOL;
            q_r.regs[`DIMS_ADR_ALIGN] <= `DIMS_RST_ALIGN;
            q_r.cfg.core_reset <= 1'b1;
            q_r.cfg.volume_level_first <= `DIMS_RST_VOL;
            q_r.cfg.volume_level_second <= `DIMS_RST_VOL;
            q_r.cfg.channel_source_sel <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign reg_rdata = q_r.rdata;
    assign zero_flag_out = q_r.zflag;
    assign cfg = q_r.cfg;
    assign mode_settling = q_r.settling;

    // -----------------------------------------------------------------
    // link domain state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic ce_meta;
        logic ce_sync;
        logic rst_meta; // core reset, first stage
        logic rst_sync;
        logic [2:0] rt_meta; // route, first stage
        logic [2:0] rt_s1;
        logic [2:0] rt_s2;
        logic [2:0] rt; // accepted route
        dims_pins_t pin_q; // input capture
        dims_lnk_out_t out;
    } dims_lnk_t;

    dims_lnk_t l_r;
    dims_lnk_t l_nxt;

    // -----------------------------------------------------------------
    // link next state: route pins by mode
    // -----------------------------------------------------------------
    always_comb begin
        l_nxt = l_r;
        l_nxt.ce_meta = ce;
        l_nxt.ce_sync = l_r.ce_meta;
        if (l_r.ce_sync) begin
            l_nxt.rst_meta = q_r.cfg.core_reset;
            l_nxt.rst_sync = l_r.rst_meta;
            l_nxt.rt_meta = q_r.route;
            l_nxt.rt_s1 = l_r.rt_meta;
            l_nxt.rt_s2 = l_r.rt_s1;
            // the word is held across the settle window; take it only
            // once two samples agree so a skewed bit is never used
            if (l_r.rt_s1 == l_r.rt_s2) begin
                l_nxt.rt = l_r.rt_s2;
            end
            l_nxt.pin_q = pins;
            l_nxt.out = '0; // unused pins never reach the datapath
            if (!l_r.rst_sync) begin
                l_nxt.out.valid = 1'b1;
                case (l_r.rt)
                    3'({DIMS_PCM, 1'b0}): begin
                        l_nxt.out.pcm_serial = l_r.pin_q.h1;
                        l_nxt.out.pcm_frame = l_r.pin_q.g1;
                    end
                    3'({DIMS_EXTF, 1'b0}): begin
                        l_nxt.out.left_bit = l_r.pin_q.h1;
                        l_nxt.out.right_bit = l_r.pin_q.g1;
                        l_nxt.out.word_clk = l_r.pin_q.word_clk;
                    end
                    3'({DIMS_DSD, 1'b0}): begin
                        l_nxt.out.left_bit = l_r.pin_q.b1;
                        l_nxt.out.right_bit = l_r.pin_q.b2;
                    end
                    3'({DIMS_DSD, 1'b1}): begin
                        l_nxt.out.left_bit = l_r.pin_q.h1;
                        l_nxt.out.right_bit = l_r.pin_q.g1;
                    end
                    default: begin
                        l_nxt.out.valid = 1'b0;
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // link registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            l_r <= '0;
            l_r.rst_meta <= 1'b1;
            l_r.rst_sync <= 1'b1;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign lnk_out = l_r.out;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_route_change;
        ce && route_now != q_r.route && !pin_ctrl;
    endsequence
    sequence s_held_reset;
        cfg.core_reset [*8];
    endsequence

    AST_PIN_FORCES_PCM: assert property (@(posedge clk_sys) disable iff (rst)
        ce && pin_ctrl && q_r.settle == 24'h0 |=> ce |-> ##1 cfg.mode == DIMS_PCM)
        else $error("pin control left pcm mode");
    AST_PIN_IGNORES_REGS: assert property (@(posedge clk_sys) disable iff (rst)
        ce && pin_ctrl |=> cfg.volume_level_first == `DIMS_RST_VOL && !cfg.mono)
        else $error("register setting leaked into pin control");
    AST_REGS_IGNORE_PINS: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !pin_ctrl |=> cfg.input_format_sel == $past(r_fmt[3:1]))
        else $error("format not taken from register");
    AST_BITSTREAM_WINS: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !pin_ctrl && r_route[`DIMS_B_BSSEL] |=> q_r.route[2:1] == 2'(DIMS_DSD))
        else $error("bitstream select did not win");
    AST_EXT_FILTER: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !pin_ctrl && !r_route[0] && r_fmt[`DIMS_B_EXT]
        |=> q_r.route[2:1] == 2'(DIMS_EXTF))
        else $error("external filter mode not entered");
    AST_SETTLE_HOLDS: assert property (@(posedge clk_sys) disable iff (rst)
        s_route_change ##1 ce [*2] |=> s_held_reset)
        else $error("datapath released too early after mode change");
    AST_ZERO_POLARITY: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !pin_ctrl |=> zero_flag_out ==
        ($past(r_filt[7] & zero_detected) ^ $past(r_route[4])))
        else $error("zero flag polarity wrong");
    AST_PCM_ONLY_EMPH: assert property (@(posedge clk_sys) disable iff (rst)
        cfg.mode != DIMS_PCM |-> cfg.emphasis_curve_sel == 2'h0 && cfg.slot_mode == 2'h0)
        else $error("pcm-only setting active outside pcm");
    AST_UNUSED_PINS: assert property (@(posedge clk_link) disable iff (rst)
        l_r.ce_sync && l_r.rt == 3'({DIMS_PCM, 1'b0}) |=> !lnk_out.left_bit)
        else $error("unused pin sampled in pcm mode");
endmodule

// ### verif/dims_src.sv
/*
 * audio source model: drives the shared and dedicated input pins.
 * assumes the bench gives the link clock, the data word and the live lines.
 */
module dims_src
    import dims_pkg::*;
(
    input wire logic clk_link,
    input wire dims_pins_t word,
    input wire dims_pins_t use_mask,
    output dims_pins_t pins
);
    // -------------------------------------------------------------
    // pin drive
    // -------------------------------------------------------------
    // known start so that idle lines can toggle from a real level
    dims_pins_t drv = '0;
    assign pins = drv;
    // idle lines toggle every cycle; a sampled idle line then shows up
    // bitstream lines join the mask only once the reset bit is set
    always @(posedge clk_link) begin
        drv <= (word & use_mask) | (~drv & ~use_mask);
    end
endmodule

// ### verif/testbench.sv
/*
 * self-checking bench for the input mode select block.
 * assumes dims_top as declared, with the filter settle shortened to 50.
 */
module testbench
    import dims_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, clk_link = 0, strap = 0, reg_wr = 0, zd = 0, rd_v = 0;
    logic ce = 1; // clock enable, dropped once to show the freeze
    logic [3:0] ra = 4'h0;
    logic [7:0] wd = 8'h00, rdata;
    logic zf, settling;
    dims_pin_cfg_t pcfg = '0;
    dims_pins_t word = '0, msk = '0, pins;
    dims_cfg_t cfg;
    dims_lnk_out_t lo;
    logic [7:0] q[$]; // expected read data, oldest first
    int err_count = 0, samples_checked = 0, seed = 85;
    logic [3:0] da [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'hC};
    logic [7:0] de [8] = '{8'h24, 8'h20, 8'h24, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00};
    dims_top #(.FILT_SETTLE_CYC(50)) uut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .control_source_strap(strap), .pin_cfg(pcfg), .reg_wr(reg_wr), .reg_addr(ra),
        .reg_wdata(wd), .reg_rdata(rdata), .zero_detected(zd), .zero_flag_out(zf),
        .cfg(cfg), .mode_settling(settling), .clk_link(clk_link), .pins(pins), .lnk_out(lo));
    dims_src src (.clk_link(clk_link), .word(word), .use_mask(msk), .pins(pins));
    initial forever #25 clk_sys = ~clk_sys;
    // link clock offset so its edges drift against the system clock
    initial begin
        #7;
        forever #24 clk_link = ~clk_link;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        ra = a;
        wd = d;
        reg_wr = 1;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask
    // read data lands one edge after the address; the monitor compares it
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        ra = a;
        q.push_back(e);
        @(negedge clk_sys);
        rd_v = 1;
        @(negedge clk_sys);
        rd_v = 0;
    endtask
    always @(posedge clk_sys) begin
        if (rd_v) begin
            chk(rdata, q.pop_front());
        end
    end
    // reset bit drops with old settings kept, the stream stops four periods
    // later, then the new mode; reset bit returns after four periods (1815)
    task automatic sw(input logic [7:0] p0, input logic [7:0] r0, input logic [7:0] r2,
        input logic [7:0] st);
        wr(4'h0, p0 & 8'hFE);
        repeat (1820) @(negedge clk_sys);
        msk = '0;
        wr(4'h2, r2);
        wr(4'h0, r0 & 8'hFE);
        repeat (1820) @(negedge clk_sys);
        wr(4'h0, r0);
        rd(4'h8, st);
        word = 6'($random(seed));
    endtask
    // waits long enough for the route word to cross to the link side
    task automatic lk(input dims_pins_t m, input dims_lnk_out_t e, input string n);
        msk = m;
        repeat (20) @(negedge clk_sys);
        chk(8'(lo), 8'(e));
        $display("test %s done", n);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 0;
        foreach (da[i]) rd(da[i], de[i]);
        ce = 0;
        wr(4'h3, 8'h10);
        ce = 1;
        rd(4'h3, 8'hFF);
        $display("test defaults done");
        wr(4'h1, 8'hA0);
        zd = 1;
        wr(4'h0, 8'h25);
        chk(8'(zf), 8'h01);
        wr(4'h2, 8'h34);
        repeat (3) @(negedge clk_sys);
        chk(8'(zf), 8'h00);
        word = 6'($random(seed));
        lk(6'h38, {1'b1, word.h1, word.g1, 3'h0}, "pcm");
        sw(8'h25, 8'h65, 8'h25, 8'h03);
        lk(6'h06, {3'h4, word.b1, word.b2, 1'b0}, "dsd dedicated");
        sw(8'h65, 8'h65, 8'h65, 8'h03);
        lk(6'h38, {3'h4, word.h1, word.g1, 1'b0}, "dsd shared");
        sw(8'h65, 8'h65, 8'h24, 8'h01);
        lk(6'h39, {3'h4, word.h1, word.g1, word.word_clk}, "ext filter");
        wr(4'h0, 8'h64);
        repeat (1820) @(negedge clk_sys);
        wr(4'h0, 8'h24);
        rd(4'h8, 8'h04);
        chk(8'(settling), 8'h01);
        repeat (60) @(negedge clk_sys);
        rd(4'h8, 8'h00);
        chk(8'(settling), 8'h00);
        $display("test filter switch done");
        rst = 1;
        strap = 1;
        pcfg.soft_silence = 1;
        repeat (4) @(negedge clk_sys);
        rst = 0;
        wr(4'h2, 8'h25);
        rd(4'h8, 8'h08);
        chk(8'(cfg.soft_silence), 8'h01);
        chk(cfg.volume_level_first, 8'hFF);
        $display("test pin control done");
        results();
    end
    initial begin
        #1000000;
        err_count++;
        results();
    end
endmodule
